// ==== src/parallel_printer_port.sv ====
// Bidirectional printer-style parallel port with host register access
// Overview of operation
// - Address 0 data latch; 1 key write, state read; 2 drive write, readback.
// - Reading the state view drops the interrupt and sets pending bit to 1.
// - Falling acknowledge edge clears state bit 2, marking interrupt pending.
// - State view bits 1 and 0 always read 1.
// - State bits 3..6 show fault, online, out-of-media, acknowledge levels.
// - State bit 7 reads the inverse of busy.
// - Readback shows actual handshake pin states and interrupt enable.
// - Readback bits 0,1,3 are 1 when low; bit 2 when high; bit 4 enable.
// - Readback bits 7 to 5 always read 1.
// - Drive bits 0,1,3 set outputs low when 1; bit 2 restart high when 1.
// - Drive bit 4 enables the interrupt output.
// - Mode pin high: drive bit 5 picks direction, 1 input; key ignored.
// - Mode pin low: key AA gives input, 55 gives output; bit 5 ignored.
// - Data latch bit n maps to data line n for reads and writes.
// - Reset: data lines output high, handshake high, restart low.
// - Output mode keeps driving the last written data until the next write.
// - Master reset loads data FF, drive 00, output mode, pending 1, interrupt low.
`timescale 1ns/1ps
module parallel_printer_port (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Host register port
    input wire logic lpt_chip_sel_n_in,
    input wire logic host_rd_n_in,
    input wire logic host_wr_n_in,
    input wire logic [1:0] host_addr_in,
    input wire logic [7:0] host_wdata_in,
    output logic [7:0] host_rdata_out,
    // Direction mode strap
    input wire logic dir_mode_pin_in,
    // Parallel data lines
    input wire logic [7:0] lpt_data_lines_in,
    output logic [7:0] lpt_data_lines_out,
    output logic lpt_data_lines_oe_out,
    // Handshake outputs
    output logic lpt_data_pulse_line_n_out,
    output logic lpt_autofeed_line_n_out,
    output logic lpt_restart_line_out,
    output logic lpt_choose_line_n_out,
    // Status inputs
    input wire logic lpt_fault_line_in,
    input wire logic lpt_online_line_in,
    input wire logic lpt_out_of_media_line_in,
    input wire logic lpt_ack_line_n_in,
    input wire logic lpt_busy_line_in,
    // Interrupt
    output logic lpt_irq_out
);
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] drive;
        logic key_input;
        logic pend_n;
        logic rd_prev;
        logic wr_prev;
        logic [7:0] rdata;
        logic [7:0] pd_out;
        logic pd_oe;
        lpt_pkg::lpt_hs_t hs;
        logic irq;
    } port_state_t;

    port_state_t s_q;
    port_state_t s_d;
    lpt_pkg::host_req_t req;
    lpt_pkg::lpt_status_t st;
    logic ack_fall;
    logic rd_act;
    logic wr_act;
    logic rd_start;
    logic wr_start;
    logic input_mode;
    logic [7:0] state_view;
    logic [7:0] readback;

    assign req = '{cs_n: lpt_chip_sel_n_in, rd_n: host_rd_n_in,
                   wr_n: host_wr_n_in, addr: host_addr_in,
                   wdata: host_wdata_in};
    assign st = '{fault: lpt_fault_line_in, online: lpt_online_line_in,
                  media: lpt_out_of_media_line_in,
                  ack_n: lpt_ack_line_n_in, busy: lpt_busy_line_in};

    // An acknowledge pulse of one clock period already covers the minimum
    lpt_fall_detect u_ack_fall (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .level_in(st.ack_n),
        .fall_out(ack_fall)
    );

    assign rd_act = ~req.cs_n & ~req.rd_n;
    assign wr_act = ~req.cs_n & ~req.wr_n;
    // One action per strobe, on its leading edge
    assign rd_start = rd_act & ~s_q.rd_prev;
    assign wr_start = wr_act & ~s_q.wr_prev;

    always_comb begin
        input_mode = dir_mode_pin_in ? s_q.drive[lpt_pkg::DRV_DIR]
                                     : s_q.key_input;
        state_view = {~st.busy, st.ack_n, st.media, st.online,
                      st.fault, s_q.pend_n, lpt_pkg::STATE_UNUSED};
        // Readback samples the registered pin drivers, the real pin states
        readback = {lpt_pkg::READBACK_UNUSED,
                    s_q.drive[lpt_pkg::DRV_IRQ_EN],
                    ~s_q.hs.choose_n, s_q.hs.restart,
                    ~s_q.hs.feed_n, ~s_q.hs.pulse_n};
    end

    always_comb begin
        s_d = s_q;
        s_d.rd_prev = rd_act;
        s_d.wr_prev = wr_act;
        if (wr_start) begin
            unique case (req.addr)
                lpt_pkg::ADDR_DATA: begin
                    s_d.data = req.wdata;
                end
                lpt_pkg::ADDR_KEY_STATE: begin
                    if (req.wdata == lpt_pkg::KEY_INPUT) begin
                        s_d.key_input = 1'b1;
                    end else if (req.wdata == lpt_pkg::KEY_OUTPUT) begin
                        s_d.key_input = 1'b0;
                    end
                    // Other key values leave direction alone
                end
                lpt_pkg::ADDR_DRIVE: begin
                    s_d.drive = req.wdata;
                end
                default: begin
                end
            endcase
        end
        // Acknowledge edge wins over a concurrent status read
        if (rd_start && req.addr == lpt_pkg::ADDR_KEY_STATE) begin
            s_d.pend_n = 1'b1;
        end
        if (ack_fall) begin
            s_d.pend_n = 1'b0;
        end
        if (rd_act) begin
            unique case (req.addr)
                lpt_pkg::ADDR_DATA: begin
                    s_d.rdata = input_mode ? lpt_data_lines_in
                                           : s_q.data;
                end
                lpt_pkg::ADDR_KEY_STATE: begin
                    s_d.rdata = state_view;
                end
                lpt_pkg::ADDR_DRIVE: begin
                    s_d.rdata = readback;
                end
                default: begin
                    s_d.rdata = 8'hff;
                end
            endcase
        end
        s_d.pd_out = s_q.data;
        s_d.pd_oe = ~input_mode;
        s_d.hs.pulse_n = ~s_q.drive[lpt_pkg::DRV_PULSE];
        s_d.hs.feed_n = ~s_q.drive[lpt_pkg::DRV_FEED];
        s_d.hs.restart = s_q.drive[lpt_pkg::DRV_RESTART];
        s_d.hs.choose_n = ~s_q.drive[lpt_pkg::DRV_CHOOSE];
        s_d.irq = ~s_d.pend_n & s_q.drive[lpt_pkg::DRV_IRQ_EN];
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s_q.data <= lpt_pkg::DATA_RST;
            s_q.drive <= lpt_pkg::DRIVE_RST;
            s_q.key_input <= 1'b0;
            s_q.pend_n <= 1'b1;
            s_q.rd_prev <= 1'b0;
            s_q.wr_prev <= 1'b0;
            s_q.rdata <= 8'h00;
            s_q.pd_out <= lpt_pkg::DATA_RST;
            s_q.pd_oe <= 1'b1;
            s_q.hs <= 4'hd;
            s_q.irq <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign host_rdata_out = s_q.rdata;
    assign lpt_data_lines_out = s_q.pd_out;
    assign lpt_data_lines_oe_out = s_q.pd_oe;
    assign lpt_data_pulse_line_n_out = s_q.hs.pulse_n;
    assign lpt_autofeed_line_n_out = s_q.hs.feed_n;
    assign lpt_restart_line_out = s_q.hs.restart;
    assign lpt_choose_line_n_out = s_q.hs.choose_n;
    assign lpt_irq_out = s_q.irq;

    // Interrupt and pending flag
    a_irq_follows: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        ##1 lpt_irq_out == (~$past(s_d.pend_n) & $past(s_q.drive[4])))
        else $error("interrupt output wrong");

    a_ack_pends: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        ack_fall |=> !s_q.pend_n)
        else $error("ack fall did not set pending");

    // The interrupt drops at the same edge as the pending bit
    a_read_clears: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        rd_start && req.addr == 2'h1 && !ack_fall
        |=> s_q.pend_n && !lpt_irq_out)
        else $error("status read did not clear pending");

    a_pend_holds: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        !ack_fall && !(rd_start && req.addr == 2'h1)
        |=> s_q.pend_n == $past(s_q.pend_n))
        else $error("pending bit changed without cause");

    a_ack_irq: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        ack_fall && s_q.drive[4] |=> lpt_irq_out)
        else $error("ack fall did not raise interrupt");

    a_irq_masked: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        !s_q.drive[4] |=> !lpt_irq_out)
        else $error("interrupt raised while disabled");

    // Read views
    a_state_ones: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        rd_act && req.addr == 2'h1 |=> host_rdata_out[1:0] == 2'h3)
        else $error("state unused bits not one");

    a_busy_inv: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        rd_act && req.addr == 2'h1 |=> host_rdata_out[7] == !$past(st.busy))
        else $error("busy bit not inverted");

    a_state_levels: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        rd_act && req.addr == 2'h1 |=> host_rdata_out[6:3] ==
        $past({st.ack_n, st.media, st.online, st.fault}))
        else $error("status levels wrong");

    a_state_pend: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        rd_act && req.addr == 2'h1 |=> host_rdata_out[2] == $past(s_q.pend_n))
        else $error("pending bit not shown");

    a_readback_hi: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        rd_act && req.addr == 2'h2 |=> host_rdata_out[7:5] == 3'h7)
        else $error("readback unused bits not one");

    a_readback_pins: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        rd_act && req.addr == 2'h2 |=> host_rdata_out[4:0] ==
        {$past(s_q.drive[4]), ~$past(lpt_choose_line_n_out),
        $past(lpt_restart_line_out), ~$past(lpt_autofeed_line_n_out),
        ~$past(lpt_data_pulse_line_n_out)})
        else $error("readback does not match pins");

    a_data_rd_out: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        rd_act && req.addr == 2'h0 && !input_mode
        |=> host_rdata_out == $past(s_q.data))
        else $error("latch read wrong");

    a_data_rd_in: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        rd_act && req.addr == 2'h0 && input_mode
        |=> host_rdata_out == $past(lpt_data_lines_in))
        else $error("pin read wrong");

    a_odd_addr: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        rd_act && req.addr == 2'h3 |=> host_rdata_out == 8'hff)
        else $error("unmapped read not all ones");

    a_rdata_hold: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        !rd_act |=> host_rdata_out == $past(host_rdata_out))
        else $error("read data changed without read");

    // Direction selection
    a_key_dir: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        wr_start && req.addr == 2'h1 && req.wdata == 8'haa && !dir_mode_pin_in
        ##1 !dir_mode_pin_in |=> !lpt_data_lines_oe_out)
        else $error("key AA did not select input");

    a_key_out: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        wr_start && req.addr == 2'h1 && req.wdata == 8'h55 |=> !s_q.key_input)
        else $error("key 55 did not select output");

    a_key_other: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        wr_start && req.addr == 2'h1 && req.wdata != 8'haa &&
        req.wdata != 8'h55 |=> s_q.key_input == $past(s_q.key_input))
        else $error("other key value changed direction");

    a_pin_dir: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        dir_mode_pin_in |=> lpt_data_lines_oe_out == !$past(s_q.drive[5]))
        else $error("drive bit 5 direction wrong");

    a_key_mode_dir: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        !dir_mode_pin_in |=> lpt_data_lines_oe_out == !$past(s_q.key_input))
        else $error("key direction wrong");

    // Data latch and handshake pins
    a_data_drive: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        wr_start && req.addr == 2'h0
        |=> ##1 lpt_data_lines_out == $past(req.wdata, 2))
        else $error("data latch not driven");

    a_data_hold: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        !(wr_start && req.addr == 2'h0) |=> s_q.data == $past(s_q.data))
        else $error("data latch changed without write");

    a_pd_follows: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        ##1 lpt_data_lines_out == $past(s_q.data))
        else $error("data lines do not follow latch");

    a_drive_write: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        wr_start && req.addr == 2'h2 |=> s_q.drive == $past(req.wdata))
        else $error("drive register not written");

    a_restart_pin: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        ##1 lpt_restart_line_out == $past(s_q.drive[2]))
        else $error("restart output wrong");

    a_pulse_pin: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        ##1 lpt_data_pulse_line_n_out == !$past(s_q.drive[0]))
        else $error("data pulse output wrong");

    a_feed_pin: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        ##1 lpt_autofeed_line_n_out == !$past(s_q.drive[1]))
        else $error("autofeed output wrong");

    a_choose_pin: assert property (@(posedge clk_in)
        disable iff (sys_rst_in)
        ##1 lpt_choose_line_n_out == !$past(s_q.drive[3]))
        else $error("choose output wrong");
endmodule

// ==== src/lpt_pkg.sv ====
// Package with register map, field positions and types for the printer port
package lpt_pkg;
    localparam logic [1:0] ADDR_DATA = 2'h0;
    localparam logic [1:0] ADDR_KEY_STATE = 2'h1;
    localparam logic [1:0] ADDR_DRIVE = 2'h2;

    localparam logic [7:0] KEY_INPUT = 8'haa;
    localparam logic [7:0] KEY_OUTPUT = 8'h55;

    localparam int DRV_PULSE = 0;
    localparam int DRV_FEED = 1;
    localparam int DRV_RESTART = 2;
    localparam int DRV_CHOOSE = 3;
    localparam int DRV_IRQ_EN = 4;
    localparam int DRV_DIR = 5;

    localparam int ST_PEND = 2;
    localparam int ST_FAULT = 3;
    localparam int ST_ONLINE = 4;
    localparam int ST_MEDIA = 5;
    localparam int ST_ACK = 6;
    localparam int ST_BUSY = 7;

    localparam logic [7:0] DATA_RST = 8'hff;
    localparam logic [7:0] DRIVE_RST = 8'h00;
    localparam logic [1:0] STATE_UNUSED = 2'h3;
    localparam logic [2:0] READBACK_UNUSED = 3'h7;

    // Minimum acknowledge low time, ns, and the clock period, ns
    localparam int ACK_MIN_NS = 75;
    localparam int CLK_NS = 100;
    localparam int ACK_MIN_CYC = (ACK_MIN_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [1:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic fault;
        logic online;
        logic media;
        logic ack_n;
        logic busy;
    } lpt_status_t;

    typedef struct packed {
        logic pulse_n;
        logic feed_n;
        logic restart;
        logic choose_n;
    } lpt_hs_t;
endpackage

// ==== src/lpt_fall_detect.sv ====
// Falling edge detector for the acknowledge input
`timescale 1ns/1ps
module lpt_fall_detect (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Level in, pulse out
    input wire logic level_in,
    output logic fall_out
);
    typedef struct packed {
        logic prev;
    } fd_state_t;

    fd_state_t s_q;
    fd_state_t s_d;

    always_comb begin
        s_d.prev = level_in;
    end

    // Start high so an input held low through reset counts as a falling edge
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s_q.prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign fall_out = s_q.prev & ~level_in;
endmodule

// ==== tb/lpt_printer_model.sv ====
// Peripheral stand-in: status levels, acknowledge pulses, input data
`timescale 1ns/1ps
module lpt_printer_model #(
    parameter int ACK_CYC = 2
) (
    // Clock
    input wire logic clk_in,
    // Bench control: fault, online, media, busy
    input wire logic [3:0] level_in,
    input wire logic [7:0] pattern_in,
    input wire logic ack_req_in,
    // Cable side
    output lpt_pkg::lpt_status_t status_out,
    output logic [7:0] data_out
);
    int left = 0;

    always @(posedge clk_in) begin
        if (ack_req_in) begin
            left <= ACK_CYC;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end

    // Two full clocks low, well past the shortest pulse the port accepts
    assign status_out = {level_in[3:1], left == 0, level_in[0]};
    assign data_out = pattern_in;
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the printer port against a reference model
`timescale 1ns/1ps
module testbench;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    lpt_pkg::host_req_t req = '{1'b1, 1'b1, 1'b1, 2'h0, 8'h00};
    logic mode = 1'b1;
    logic [3:0] lvl = 4'h0;
    logic [7:0] pat = 8'h00;
    logic ack_req = 1'b0;
    lpt_pkg::lpt_status_t st;
    logic [7:0] rdata, dout, dmodel, dwire, v;
    logic oe, pulse_n, feed_n, restart, choose_n, irq;
    logic [7:0] drv = 8'h00;
    logic [7:0] latch = 8'hff;
    logic key_in = 1'b0;
    logic pend = 1'b1;
    logic [7:0] keys [5] = '{8'h55, 8'haa, 8'h3c, 8'h00, 8'h55};
    int failures = 0;
    int comparisons = 0;

    always #50 clk_in = ~clk_in;
    // Pin level: whoever has the lines drives them
    assign dwire = oe ? dout : dmodel;

    parallel_printer_port uut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .lpt_chip_sel_n_in(req.cs_n), .host_rd_n_in(req.rd_n),
        .host_wr_n_in(req.wr_n), .host_addr_in(req.addr),
        .host_wdata_in(req.wdata), .host_rdata_out(rdata),
        .dir_mode_pin_in(mode), .lpt_data_lines_in(dwire),
        .lpt_data_lines_out(dout), .lpt_data_lines_oe_out(oe),
        .lpt_data_pulse_line_n_out(pulse_n),
        .lpt_autofeed_line_n_out(feed_n),
        .lpt_restart_line_out(restart), .lpt_choose_line_n_out(choose_n),
        .lpt_fault_line_in(st.fault), .lpt_online_line_in(st.online),
        .lpt_out_of_media_line_in(st.media), .lpt_ack_line_n_in(st.ack_n),
        .lpt_busy_line_in(st.busy), .lpt_irq_out(irq));

    lpt_printer_model peer (
        .clk_in(clk_in), .level_in(lvl), .pattern_in(pat),
        .ack_req_in(ack_req), .status_out(st), .data_out(dmodel));

    function automatic logic dir_in();
        return mode ? drv[5] : key_in;
    endfunction

    function automatic logic [7:0] st_exp();
        return {~lvl[0], 1'b1, lvl[1], lvl[2], lvl[3], pend, 2'h3};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        req = '{1'b0, 1'b1, 1'b0, a, d};
        @(posedge clk_in);
        #1;
        req.cs_n = 1'b1;
        req.wr_n = 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        req = '{1'b0, 1'b0, 1'b1, a, 8'h00};
        @(posedge clk_in);
        #1;
        req.cs_n = 1'b1;
        req.rd_n = 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        check(rdata, exp);
        if (a == 2'h1) pend = 1'b1;
    endtask

    task automatic pins();
        check({oe, pulse_n, feed_n, restart, choose_n, irq, 2'h0},
            {~dir_in(), ~drv[0], ~drv[1], drv[2], ~drv[3],
            ~pend & drv[4], 2'h0});
        if (!dir_in()) check(dout, latch);
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clk_in);
        failures++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(2999));
        repeat (2) @(posedge clk_in);
        #1;
        sys_rst_in = 1'b0;
        pins();
        rd(2'h2, 8'he0);
        rd(2'h1, st_exp());
        for (int i = 0; i < 12; i++) begin
            lvl = 4'($urandom);
            pat = 8'($urandom);
            v = 8'($urandom);
            wr(2'h0, v);
            latch = v;
            v = 8'($urandom);
            wr(2'h2, v);
            drv = v;
            pins();
            rd(2'h2, {3'h7, drv[4:0]});
            rd(2'h0, dir_in() ? pat : latch);
            if (i % 2 == 1) begin
                ack_req = 1'b1;
                @(posedge clk_in);
                #1;
                ack_req = 1'b0;
                repeat (4) @(posedge clk_in);
                #1;
                pend = 1'b0;
                pins();
            end
            rd(2'h1, st_exp());
            pins();
        end
        mode = 1'b0;
        for (int i = 0; i < 5; i++) begin
            wr(2'h2, {2'h0, ~key_in, 5'h00});
            drv = {2'h0, ~key_in, 5'h00};
            wr(2'h1, keys[i]);
            if (keys[i] == 8'haa) key_in = 1'b1;
            if (keys[i] == 8'h55) key_in = 1'b0;
            pins();
            rd(2'h0, dir_in() ? pat : latch);
        end
        rd(2'h3, 8'hff);
        tally_and_finish();
    end
endmodule
